// ===== design/mmbd_top.sv
// Purpose: program and data memory address decoding for an 8-bit core
// Assumes: the core issues at most one data access per cycle
// Notes: peripheral registers are not held here and read as zero
//
// Contract
// - Program counter is 13 bits wide, spanning 8K words of 14 bits.
// - Only program words 0000h to 03FFh exist as storage.
// - Fetches above 1K wrap onto the matching word in the first 1K.
// - Reset starts at 0000h; an interrupt loads the counter with 0004h.
// - Data memory has two banks; low 32 locations of each are special registers.
// - Addresses 20h-5Fh hit shared RAM; bank one A0h-DFh aliases it.
// - Any other data location is unimplemented and reads zero.
// - Core flags bit 5 picks bank zero or bank one for direct accesses.
// - The general-purpose register file is 64 entries of 8 bits.
// - Each entry is reachable directly and through the indirect pointer.
`timescale 1ns/1ps
module mmbd_top (
    // clock and reset
    input wire logic clk_in,
    input wire logic arst_n_in,
    input wire logic clk_en_in,
    // program counter control from the core
    input wire logic pc_step_in,
    input wire logic pc_jump_in,
    input wire logic [12:0] pc_target_in,
    input wire logic int_take_in,
    // program side outputs
    output logic [12:0] pc_out,
    output logic [9:0] prog_addr_out,
    // data access from the core
    input wire logic [6:0] dat_addr_in,
    input wire logic dat_rd_in,
    input wire logic dat_wr_in,
    input wire logic [7:0] dat_wdata_in,
    output logic [7:0] dat_rdata_out,
    output logic dat_valid_out,
    // arithmetic flag update from the core
    input wire logic alu_flags_we_in,
    input wire logic [2:0] alu_flags_in,
    // core register views
    output logic [7:0] core_flags_out,
    output logic bank_select_bit_out,
    output logic [7:0] indirect_pointer_out,
    output logic [4:0] pc_upper_latch_out,
    output logic [7:0] interrupt_control_reg_out
);

    // core registers, one physical copy each
    logic [7:0] core_flags_q;
    logic [7:0] core_flags_d;
    logic [7:0] indirect_pointer_q;
    logic [7:0] indirect_pointer_d;
    logic [4:0] pc_upper_latch_q;
    logic [4:0] pc_upper_latch_d;
    logic [7:0] interrupt_control_reg_q;
    logic [7:0] interrupt_control_reg_d;
    logic [7:0] dat_rdata_q;
    logic [7:0] dat_rdata_d;
    logic dat_valid_q;
    logic [9:0] prog_addr_q;

    // program counter value from the counter unit
    logic [12:0] pc_w;
    logic [12:0] pc_next_fetch_w;

    // address decode wires
    logic is_indirect_w;
    logic bank_w;
    logic [7:0] eff_addr_w;
    logic [6:0] ofs_w;
    logic in_sfr_w;
    logic in_gpr_w;
    logic hit_port_w;
    logic hit_pcl_w;
    logic hit_flags_w;
    logic hit_fsr_w;
    logic hit_latch_w;
    logic hit_intc_w;
    logic [5:0] gpr_addr_w;
    logic gpr_wr_w;
    logic [7:0] gpr_rdata_w;
    logic [7:0] sfr_rdata_w;
    logic pcl_wr_w;

    // direct or indirect effective address
    assign is_indirect_w = (dat_addr_in == mmbd_pkg::OFS_INDIRECT_DATA_PORT);
    assign bank_w = core_flags_q[mmbd_pkg::FLG_BANK_SEL];
    // the indirect bank bit is reserved, so the pointer alone forms the address
    assign eff_addr_w = is_indirect_w ? indirect_pointer_q : {bank_w, dat_addr_in};
    // offset within the bank; the bank bit is dropped, so both banks decode alike
    assign ofs_w = eff_addr_w[6:0];

    // region decode
    assign in_sfr_w = (ofs_w < mmbd_pkg::SFR_LIMIT);
    assign in_gpr_w = (ofs_w >= mmbd_pkg::GPR_BASE) && (ofs_w <= mmbd_pkg::GPR_LAST);

    // core register hits, same offset in either bank
    assign hit_port_w = (ofs_w == mmbd_pkg::OFS_INDIRECT_DATA_PORT);
    assign hit_pcl_w = (ofs_w == mmbd_pkg::OFS_PC_LOW_BYTE);
    assign hit_flags_w = (ofs_w == mmbd_pkg::OFS_CORE_FLAGS);
    assign hit_fsr_w = (ofs_w == mmbd_pkg::OFS_INDIRECT_POINTER);
    assign hit_latch_w = (ofs_w == mmbd_pkg::OFS_PC_UPPER_LATCH);
    assign hit_intc_w = (ofs_w == mmbd_pkg::OFS_INT_CONTROL);

    // shared RAM index: both banks fold onto the same 64 entries
    assign gpr_addr_w = 6'(ofs_w - mmbd_pkg::GPR_BASE);
    assign gpr_wr_w = dat_wr_in && in_gpr_w;
    assign pcl_wr_w = dat_wr_in && hit_pcl_w;

    // special register read mux, the port and all others read zero
    assign sfr_rdata_w = hit_pcl_w ? pc_w[7:0] :
                         hit_flags_w ? core_flags_q :
                         hit_fsr_w ? indirect_pointer_q :
                         hit_latch_w ? {3'h0, pc_upper_latch_q} :
                         hit_intc_w ? interrupt_control_reg_q :
                         mmbd_pkg::ZERO_BYTE;

    // read data selection by region
    assign dat_rdata_d = in_gpr_w ? gpr_rdata_w :
                         in_sfr_w ? sfr_rdata_w :
                         mmbd_pkg::ZERO_BYTE;

    // core flags: software writes only the writable bits, arithmetic update wins
    always_comb begin
        core_flags_d = core_flags_q;
        if (dat_wr_in && hit_flags_w) begin
            core_flags_d = (core_flags_q & ~mmbd_pkg::FLG_SW_MASK)
                         | (dat_wdata_in & mmbd_pkg::FLG_SW_MASK);
        end
        if (alu_flags_we_in) begin
            core_flags_d = (core_flags_d & ~mmbd_pkg::FLG_ALU_MASK) | {5'h00, alu_flags_in};
        end
    end

    // pointer, latch and interrupt control writes
    assign indirect_pointer_d = (dat_wr_in && hit_fsr_w) ? dat_wdata_in : indirect_pointer_q;
    assign pc_upper_latch_d = (dat_wr_in && hit_latch_w) ? dat_wdata_in[4:0] : pc_upper_latch_q;
    assign interrupt_control_reg_d = (dat_wr_in && hit_intc_w) ? dat_wdata_in
                                                               : interrupt_control_reg_q;

    // fetch address follows the counter value it will hold next
    assign pc_next_fetch_w = int_take_in ? mmbd_pkg::INT_VEC :
                             pcl_wr_w ? {pc_upper_latch_q, dat_wdata_in} :
                             pc_jump_in ? pc_target_in :
                             pc_step_in ? (pc_w + mmbd_pkg::PC_ONE) : pc_w;

    // core register state
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            core_flags_q <= mmbd_pkg::CORE_FLAGS_RST;
            indirect_pointer_q <= mmbd_pkg::INDIRECT_POINTER_RST;
            pc_upper_latch_q <= mmbd_pkg::PC_UPPER_LATCH_RST;
            interrupt_control_reg_q <= mmbd_pkg::INT_CONTROL_RST;
        end else if (clk_en_in) begin
            core_flags_q <= core_flags_d;
            indirect_pointer_q <= indirect_pointer_d;
            pc_upper_latch_q <= pc_upper_latch_d;
            interrupt_control_reg_q <= interrupt_control_reg_d;
        end
    end

    // registered read data, valid one cycle after a read
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            dat_rdata_q <= mmbd_pkg::ZERO_BYTE;
            dat_valid_q <= 1'b0;
        end else if (clk_en_in) begin
            dat_valid_q <= dat_rd_in;
            if (dat_rd_in) begin
                dat_rdata_q <= dat_rdata_d;
            end
        end
    end

    // program storage address, upper counter bits are dropped
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            prog_addr_q <= mmbd_pkg::RESET_VEC[9:0];
        end else if (clk_en_in) begin
            prog_addr_q <= pc_next_fetch_w[9:0];
        end
    end

    // program counter
    mmbd_pc_unit u_pc (
        .clk_in(clk_in),
        .arst_n_in(arst_n_in),
        .clk_en_in(clk_en_in),
        .int_take_in(int_take_in),
        .low_wr_in(pcl_wr_w),
        .low_data_in(dat_wdata_in),
        .latch_in(pc_upper_latch_q),
        .jump_in(pc_jump_in),
        .target_in(pc_target_in),
        .step_in(pc_step_in),
        .pc_out(pc_w)
    );

    // shared general-purpose RAM
    mmbd_gpr_ram u_gpr (
        .clk_in(clk_in),
        .clk_en_in(clk_en_in),
        .addr_in(gpr_addr_w),
        .wr_in(gpr_wr_w),
        .wdata_in(dat_wdata_in),
        .rdata_out(gpr_rdata_w)
    );

    // outputs, all from flip-flops
    assign pc_out = pc_w;
    assign prog_addr_out = prog_addr_q;
    assign dat_rdata_out = dat_rdata_q;
    assign dat_valid_out = dat_valid_q;
    assign core_flags_out = core_flags_q;
    assign bank_select_bit_out = core_flags_q[mmbd_pkg::FLG_BANK_SEL];
    assign indirect_pointer_out = indirect_pointer_q;
    assign pc_upper_latch_out = pc_upper_latch_q;
    assign interrupt_control_reg_out = interrupt_control_reg_q;

endmodule

// ===== design/mmbd_pkg.sv
// Purpose: shared constants for the memory map and bank decoder
// Assumes: 8-bit data path, 14-bit program words, one core clock
// Notes: all offsets are file addresses within one bank (7 bits)
package mmbd_pkg;

    // program side
    localparam int PC_W = 13;
    localparam int PROG_AW = 10;
    localparam int LATCH_W = 5;
    localparam logic [12:0] RESET_VEC = 13'h0000;
    localparam logic [12:0] INT_VEC = 13'h0004;
    localparam logic [12:0] PC_ONE = 13'h0001;

    // data side geometry
    localparam int DW = 8;
    localparam int FILE_AW = 7;
    localparam int EFF_AW = 8;
    localparam int GPR_AW = 6;
    localparam int GPR_DEPTH = 64;
    localparam logic [6:0] SFR_LIMIT = 7'h20;
    localparam logic [6:0] GPR_BASE = 7'h20;
    localparam logic [6:0] GPR_LAST = 7'h5F;

    // core register offsets, same in both banks
    localparam logic [6:0] OFS_INDIRECT_DATA_PORT = 7'h00;
    localparam logic [6:0] OFS_PC_LOW_BYTE = 7'h02;
    localparam logic [6:0] OFS_CORE_FLAGS = 7'h03;
    localparam logic [6:0] OFS_INDIRECT_POINTER = 7'h04;
    localparam logic [6:0] OFS_PC_UPPER_LATCH = 7'h0A;
    localparam logic [6:0] OFS_INT_CONTROL = 7'h0B;

    // core flags field positions
    localparam int FLG_INDIRECT_BANK = 7;
    localparam int FLG_UPPER_BANK = 6;
    localparam int FLG_BANK_SEL = 5;
    localparam int FLG_TIMEOUT = 4;
    localparam int FLG_POWERDOWN = 3;
    localparam logic [7:0] FLG_SW_MASK = 8'hE7;
    localparam logic [7:0] FLG_ALU_MASK = 8'h07;

    // reset values
    localparam logic [7:0] CORE_FLAGS_RST = 8'h18;
    localparam logic [7:0] INDIRECT_POINTER_RST = 8'h00;
    localparam logic [4:0] PC_UPPER_LATCH_RST = 5'h00;
    localparam logic [7:0] INT_CONTROL_RST = 8'h00;
    localparam logic [7:0] ZERO_BYTE = 8'h00;

endpackage

// ===== design/mmbd_gpr_ram.sv
// Purpose: shared general-purpose register file, 64 entries of 8 bits
// Assumes: one access per cycle, write is clocked, read is combinational
// Notes: storage has no reset; contents are unknown after power-up
`timescale 1ns/1ps
module mmbd_gpr_ram (
    // clock
    input wire logic clk_in,
    input wire logic clk_en_in,
    // access port
    input wire logic [5:0] addr_in,
    input wire logic wr_in,
    input wire logic [7:0] wdata_in,
    output logic [7:0] rdata_out
);

    logic [7:0] mem_q [mmbd_pkg::GPR_DEPTH];

    // one storage cell per entry, written only when enabled
    always_ff @(posedge clk_in) begin
        if (clk_en_in && wr_in) begin
            mem_q[addr_in] <= wdata_in;
        end
    end

    // read path feeds the registered read data in the top
    assign rdata_out = mem_q[addr_in];

endmodule

// ===== design/mmbd_pc_unit.sv
// Purpose: 13-bit program counter with reset and interrupt vectors, wrapping at 8K
// Assumes: at most one of the load sources wins per cycle, by priority
// Notes: priority is interrupt, then low-byte write, then jump, then step
`timescale 1ns/1ps
module mmbd_pc_unit (
    // clock and reset
    input wire logic clk_in,
    input wire logic arst_n_in,
    input wire logic clk_en_in,
    // load sources
    input wire logic int_take_in,
    input wire logic low_wr_in,
    input wire logic [7:0] low_data_in,
    input wire logic [4:0] latch_in,
    input wire logic jump_in,
    input wire logic [12:0] target_in,
    input wire logic step_in,
    // counter
    output logic [12:0] pc_out
);

    logic [12:0] pc_q;
    logic [12:0] pc_d;

    // next value selection
    always_comb begin
        pc_d = pc_q;
        if (int_take_in) begin
            pc_d = mmbd_pkg::INT_VEC;
        end else if (low_wr_in) begin
            pc_d = {latch_in, low_data_in};
        end else if (jump_in) begin
            pc_d = target_in;
        end else if (step_in) begin
            pc_d = pc_q + mmbd_pkg::PC_ONE;
        end
    end

    // counter register, starts at the reset vector
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            pc_q <= mmbd_pkg::RESET_VEC;
        end else if (clk_en_in) begin
            pc_q <= pc_d;
        end
    end

    assign pc_out = pc_q;

endmodule

// ===== dv/mmbd_monitor.sv
// Purpose: port checker for mmbd_top
// Assumes: one clock, async active-low reset
// Notes: attached by bind after the module
`timescale 1ns/1ps
module mmbd_monitor (
    // clock and reset
    input wire logic clk_in,
    input wire logic arst_n_in,
    input wire logic clk_en_in,
    // core requests
    input wire logic pc_step_in,
    input wire logic pc_jump_in,
    input wire logic [12:0] pc_target_in,
    input wire logic int_take_in,
    input wire logic [6:0] dat_addr_in,
    input wire logic dat_rd_in,
    input wire logic dat_wr_in,
    input wire logic [7:0] dat_wdata_in,
    // design outputs
    input wire logic [12:0] pc_out,
    input wire logic [9:0] prog_addr_out,
    input wire logic [7:0] dat_rdata_out,
    input wire logic dat_valid_out,
    input wire logic [7:0] core_flags_out,
    input wire logic bank_select_bit_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!arst_n_in);
    // low-byte write outranks jump and step
    wire pcl_wr = dat_wr_in && dat_addr_in == 7'h02;
    wire rd_go = clk_en_in && dat_rd_in;
    // request sequences
    sequence s_rd;
        clk_en_in && dat_rd_in;
    endsequence
    sequence s_step;
        clk_en_in && pc_step_in && !int_take_in && !pc_jump_in && !pcl_wr;
    endsequence
    sequence s_jump;
        clk_en_in && pc_jump_in && !int_take_in && !pcl_wr;
    endsequence
    // properties
    property p_wrap;
        prog_addr_out == pc_out[9:0];
    endproperty
    property p_int;
        clk_en_in && int_take_in |=> pc_out == 13'h0004;
    endproperty
    property p_step;
        s_step |=> pc_out == $past(pc_out) + 13'h0001;
    endproperty
    property p_jump;
        s_jump |=> pc_out == $past(pc_target_in);
    endproperty
    property p_valid;
        s_rd |=> dat_valid_out;
    endproperty
    // a frozen cycle keeps the last answer standing, so only enabled idle cycles clear it
    property p_pulse;
        clk_en_in && !rd_go |=> !dat_valid_out && $stable(dat_rdata_out);
    endproperty
    property p_unimp;
        s_rd ##0 (dat_addr_in >= 7'h60) |=> dat_rdata_out == 8'h00;
    endproperty
    property p_bank;
        clk_en_in && dat_wr_in && dat_addr_in == 7'h03 |=>
            bank_select_bit_out == $past(dat_wdata_in[5]);
    endproperty
    property p_freeze;
        !clk_en_in |=> $stable(pc_out) && $stable(prog_addr_out) && $stable(core_flags_out)
            && $stable(dat_valid_out);
    endproperty
    a_wrap: assert property (p_wrap) else $error("fetch address off pc");
    a_int: assert property (p_int) else $error("no interrupt vector");
    a_step: assert property (p_step) else $error("bad pc step");
    a_jump: assert property (p_jump) else $error("bad pc jump");
    a_valid: assert property (p_valid) else $error("no read answer");
    a_pulse: assert property (p_pulse) else $error("stray read answer");
    a_unimp: assert property (p_unimp) else $error("unimplemented not zero");
    a_bank: assert property (p_bank) else $error("bank bit not as written");
    a_freeze: assert property (p_freeze) else $error("state moved while frozen");
endmodule

bind mmbd_top mmbd_monitor u_mon (
    .clk_in(clk_in), .arst_n_in(arst_n_in), .clk_en_in(clk_en_in),
    .pc_step_in(pc_step_in), .pc_jump_in(pc_jump_in), .pc_target_in(pc_target_in),
    .int_take_in(int_take_in), .dat_addr_in(dat_addr_in), .dat_rd_in(dat_rd_in),
    .dat_wr_in(dat_wr_in), .dat_wdata_in(dat_wdata_in),
    .pc_out(pc_out), .prog_addr_out(prog_addr_out),
    .dat_rdata_out(dat_rdata_out), .dat_valid_out(dat_valid_out),
    .core_flags_out(core_flags_out), .bank_select_bit_out(bank_select_bit_out)
);

// ===== dv/mmbd_core_model.sv
// Purpose: behavioural core issuing data accesses
// Assumes: requests launched at a rising edge
// Notes: released write data is inverted so stale bytes never pass
`timescale 1ns/1ps
module mmbd_core_model (
    // clock
    input wire logic clk_in,
    // data access
    output logic [6:0] dat_addr_out,
    output logic dat_rd_out,
    output logic dat_wr_out,
    output logic [7:0] dat_wdata_out,
    input wire logic [7:0] dat_rdata_in,
    input wire logic dat_valid_in
);
    // idle bus
    initial begin
        dat_addr_out = 7'h7F;
        dat_rd_out = 1'b0;
        dat_wr_out = 1'b0;
        dat_wdata_out = 8'h00;
    end
    // one write; flag writes keep the reserved bits clear
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        @(posedge clk_in);
        dat_addr_out <= a;
        dat_wr_out <= 1'b1;
        dat_wdata_out <= (a == 7'h03) ? (d & 8'h3F) : d;
        @(posedge clk_in);
        dat_wr_out <= 1'b0;
        dat_wdata_out <= ~dat_wdata_out;
        #1;
    endtask
    // one read; answer taken after the edge that accepts it
    task automatic rd(input logic [6:0] a, output logic [7:0] d, output logic v);
        @(posedge clk_in);
        dat_addr_out <= a;
        dat_rd_out <= 1'b1;
        @(posedge clk_in);
        dat_rd_out <= 1'b0;
        #1;
        d = dat_rdata_in;
        v = dat_valid_in;
    endtask
endmodule

// ===== dv/tb.sv
// Purpose: self-checking bench for mmbd_top
// Assumes: 40 MHz clock, reset held 20 cycles
// Notes: core model drives the data side, bench the pc side
`timescale 1ns/1ps
module tb;
    logic clk_in = 1'b0;
    logic arst_n_in = 1'b0;
    logic clk_en_in = 1'b1;
    logic pc_step_in = 1'b0;
    logic pc_jump_in = 1'b0;
    logic [12:0] pc_target_in = 13'h0000;
    logic int_take_in = 1'b0;
    logic alu_flags_we_in = 1'b0;
    logic [2:0] alu_flags_in = 3'h0;
    logic [6:0] dat_addr;
    logic dat_rd;
    logic dat_wr;
    logic [7:0] dat_wdata;
    logic [7:0] dat_rdata;
    logic dat_valid;
    logic [12:0] pc_out;
    logic [9:0] prog_addr;
    logic [7:0] flags;
    logic bank_bit;
    logic [7:0] pointer;
    logic [4:0] latch;
    logic [7:0] int_ctl;
    int errors = 0;
    int total_checks = 0;
    // clock
    always #12.5 clk_in = ~clk_in;
    mmbd_top i_mmbd_top (
        .clk_in(clk_in), .arst_n_in(arst_n_in), .clk_en_in(clk_en_in),
        .pc_step_in(pc_step_in), .pc_jump_in(pc_jump_in), .pc_target_in(pc_target_in),
        .int_take_in(int_take_in), .pc_out(pc_out), .prog_addr_out(prog_addr),
        .dat_addr_in(dat_addr), .dat_rd_in(dat_rd), .dat_wr_in(dat_wr),
        .dat_wdata_in(dat_wdata), .dat_rdata_out(dat_rdata), .dat_valid_out(dat_valid),
        .alu_flags_we_in(alu_flags_we_in), .alu_flags_in(alu_flags_in),
        .core_flags_out(flags), .bank_select_bit_out(bank_bit),
        .indirect_pointer_out(pointer), .pc_upper_latch_out(latch),
        .interrupt_control_reg_out(int_ctl)
    );
    mmbd_core_model i_mmbd_core_model (
        .clk_in(clk_in), .dat_addr_out(dat_addr), .dat_rd_out(dat_rd),
        .dat_wr_out(dat_wr), .dat_wdata_out(dat_wdata),
        .dat_rdata_in(dat_rdata), .dat_valid_in(dat_valid)
    );
    // compare and count
    task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
        total_checks++;
        if (s !== e) begin
            errors++;
            $display("BAD %s exp %h seen %h", n, e, s);
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // register values straight after reset
    task automatic t_reset();
        chk("pc", 16'(pc_out), 16'h0000);
        chk("fetch", 16'(prog_addr), 16'h0000);
        chk("flags", 16'(flags), 16'h0018);
        chk("bank", 16'(bank_bit), 16'h0000);
        chk("ptr", 16'(pointer), 16'h0000);
        chk("latch", 16'(latch), 16'h0000);
        chk("intctl", 16'(int_ctl), 16'h0000);
        chk("rdata", {7'h00, dat_valid, dat_rdata}, 16'h0000);
        $display("t_reset done");
    endtask
    // banks, shared ram, unimplemented and indirect access
    task automatic t_data();
        logic [7:0] d;
        logic v;
        i_mmbd_core_model.wr(7'h20, 8'hA5);
        i_mmbd_core_model.wr(7'h5F, 8'h3C);
        i_mmbd_core_model.rd(7'h20, d, v);
        chk("rd20", {7'h00, v, d}, 16'h01A5);
        i_mmbd_core_model.wr(7'h03, 8'hE0);
        chk("flags", 16'(flags), 16'h0038);
        chk("bank", 16'(bank_bit), 16'h0001);
        i_mmbd_core_model.rd(7'h20, d, v);
        chk("rdA0", 16'(d), 16'h00A5);
        i_mmbd_core_model.rd(7'h5F, d, v);
        chk("rdDF", 16'(d), 16'h003C);
        i_mmbd_core_model.rd(7'h60, d, v);
        chk("rdE0", 16'(d), 16'h0000);
        i_mmbd_core_model.wr(7'h04, 8'h5F);
        i_mmbd_core_model.rd(7'h00, d, v);
        chk("ind", 16'(d), 16'h003C);
        i_mmbd_core_model.wr(7'h04, 8'h80);
        i_mmbd_core_model.wr(7'h00, 8'h77);
        i_mmbd_core_model.rd(7'h00, d, v);
        chk("port", 16'(d), 16'h0000);
        i_mmbd_core_model.rd(7'h04, d, v);
        chk("ptr84", 16'(d), 16'h0080);
        i_mmbd_core_model.wr(7'h0A, 8'h05);
        chk("latch", 16'(latch), 16'h0005);
        i_mmbd_core_model.wr(7'h0B, 8'h5A);
        chk("intctl", 16'(int_ctl), 16'h005A);
        i_mmbd_core_model.wr(7'h03, 8'h00);
        chk("bank0", 16'(bank_bit), 16'h0000);
        i_mmbd_core_model.rd(7'h0B, d, v);
        chk("rd0B", 16'(d), 16'h005A);
        // arithmetic update touches only the low three flag bits
        @(posedge clk_in);
        alu_flags_we_in <= 1'b1;
        alu_flags_in <= 3'h5;
        @(posedge clk_in);
        alu_flags_we_in <= 1'b0;
        #1;
        chk("alu", 16'(flags), 16'h001D);
        i_mmbd_core_model.rd(7'h60, d, v);
        chk("rd60", 16'(d), 16'h0000);
        $display("t_data done");
    endtask
    // jump, step across 8K, interrupt vector, low-byte load, freeze
    task automatic t_pc();
        logic [7:0] d;
        logic v;
        @(posedge clk_in);
        pc_jump_in <= 1'b1;
        pc_target_in <= 13'h1FFE;
        @(posedge clk_in);
        pc_jump_in <= 1'b0;
        pc_step_in <= 1'b1;
        #1;
        chk("jump", {3'h0, prog_addr, 3'h0}, 16'h1FF0);
        @(posedge clk_in);
        #1;
        chk("step", 16'(pc_out), 16'h1FFF);
        @(posedge clk_in);
        pc_step_in <= 1'b0;
        #1;
        chk("roll", 16'(pc_out), 16'h0000);
        @(posedge clk_in);
        int_take_in <= 1'b1;
        @(posedge clk_in);
        int_take_in <= 1'b0;
        #1;
        chk("vec", 16'(pc_out), 16'h0004);
        i_mmbd_core_model.wr(7'h02, 8'h9A);
        chk("pcl", 16'(pc_out), 16'h059A);
        chk("wrap", 16'(prog_addr), 16'h019A);
        i_mmbd_core_model.rd(7'h02, d, v);
        chk("rdpcl", 16'(d), 16'h009A);
        // a low clock enable must hold the counter against a step request
        @(posedge clk_in);
        clk_en_in <= 1'b0;
        pc_step_in <= 1'b1;
        repeat (3) @(posedge clk_in);
        #1;
        chk("hold", 16'(pc_out), 16'h059A);
        @(posedge clk_in);
        clk_en_in <= 1'b1;
        @(posedge clk_in);
        pc_step_in <= 1'b0;
        #1;
        chk("run", 16'(prog_addr), 16'h019B);
        $display("t_pc done");
    endtask
    // reset again in mid-run, every core register returns to its reset value
    task automatic t_rerst();
        @(posedge clk_in);
        arst_n_in <= 1'b0;
        repeat (2) @(posedge clk_in);
        arst_n_in <= 1'b1;
        #1;
        t_reset();
    endtask
    // main sequence
    initial begin
        repeat (20) @(posedge clk_in);
        arst_n_in <= 1'b1;
        #1;
        t_reset();
        t_data();
        t_pc();
        t_rerst();
        close_out();
    end
    // watchdog
    initial begin
        #75000;
        errors++;
        close_out();
    end
endmodule
